//--- logic/ifc_combiner.v
// Purpose: Sixteen-source fast/normal interrupt combiner with acknowledge
//          locations, idle and standby entry.
// Assumes: All inputs synchronous to core_clk_in; location strobes are
//          one-cycle write pulses decoded elsewhere.
// Notes:   What this block does is listed below.
//
// What this block does
// RL1: Sixteen sources, twelve normal, four fast
// RL2: Twelve sources combine onto normal request
// RL3: Fast class outranks normal; no intra-class order
// RL4: Level sources stay pending while asserted
// RL5: Request only for enabled active sources
// RL6: Status shows currently active sources
// RL7: Software clears sources at the peripheral
// RL8: Battery-low write clears battery-fall latch
// RL9: Media rising edge latched, write clears
// RL10: Tick write clears tick and watchdog
// RL11: Timer one write clears its underflow
// RL12: Timer two write clears its underflow
// RL13: Clock match write clears compare interrupt
// RL14: Modem write clears modem-change interrupt
// RL15: Sound write clears sound interrupt
// RL16: Idle write stops processor clock until interrupt
// RL17: Idle with all masked needs reset
// RL18: Standby stops oscillator, optional self-refresh
// RL19: Standby waits for DRAM cycle boundary
// RL20: Bits 0-3 fast, 4-15 normal
// RL21: Serial done cleared by data read
// RL22: Locations act on any write only
// RL23: Outputs OR enabled sources every cycle
`timescale 1ns/1ps
`include "ifc_consts.vh"

module ifc_combiner #(
    parameter NUM_SRC = `IFC_NUM_SRC
) (
    input  wire               core_clk_in,
    input  wire               rstn_in,
    input  wire [NUM_SRC-1:0] mask_in,
    input  wire               external_fast_request_in,
    input  wire               battery_good_input_in,
    input  wire               watchdog_expired_in,
    input  wire               media_change_input_in,
    input  wire               sound_request_in,
    input  wire [2:0]         ext_request_in,
    input  wire               first_timer_underflow_in,
    input  wire               second_timer_underflow_in,
    input  wire               clock_match_in,
    input  wire               tick_in,
    input  wire               uart_tx_request_in,
    input  wire               uart_rx_request_in,
    input  wire               modem_change_in,
    input  wire               serial_transfer_done_request_in,
    input  wire               serial_adc_data_reg_rd_in,
    input  wire               battery_low_ack_loc_wr_in,
    input  wire               media_change_ack_loc_wr_in,
    input  wire               tick_ack_loc_wr_in,
    input  wire               timer_one_ack_loc_wr_in,
    input  wire               timer_two_ack_loc_wr_in,
    input  wire               clock_match_ack_loc_wr_in,
    input  wire               modem_change_ack_loc_wr_in,
    input  wire               sound_ack_loc_wr_in,
    input  wire               idle_entry_loc_wr_in,
    input  wire               standby_entry_loc_wr_in,
    input  wire               refresh_enable_bit_in,
    input  wire               dram_cycle_busy_in,
    input  wire               wake_in,
    output reg  [NUM_SRC-1:0] status_out,
    output reg                fast_req_out,
    output reg                norm_req_out,
    output wire               cpu_clk_gate_out,
    output wire               osc_stop_out,
    output reg                self_refresh_out
);

    reg  [NUM_SRC-1:0] latch_q;
    reg                batt_good_d;
    reg                media_d;
    reg  [1:0]         pwr_state;
    reg  [1:0]         next_pwr_state;
    wire [NUM_SRC-1:0] raw;
    wire [NUM_SRC-1:0] set_ev;
    wire [NUM_SRC-1:0] clr_ev;
    wire [NUM_SRC-1:0] active;
    wire [NUM_SRC-1:0] enabled;
    wire               any_enabled;

    // RL4: level sources
    assign raw[`IFC_BIT_EXT_FAST]  = external_fast_request_in;
    assign raw[`IFC_BIT_SOUND]     = sound_request_in;
    assign raw[`IFC_BIT_EXT3:`IFC_BIT_EXT1] = ext_request_in;
    assign raw[`IFC_BIT_UART_TX]   = uart_tx_request_in;
    assign raw[`IFC_BIT_UART_RX]   = uart_rx_request_in;
    assign raw[`IFC_BIT_BATT_LOW]  = 1'b0;
    assign raw[`IFC_BIT_WATCHDOG]  = 1'b0;
    assign raw[`IFC_BIT_MEDIA]     = 1'b0;
    assign raw[`IFC_BIT_TIMER_ONE] = 1'b0;
    assign raw[`IFC_BIT_TIMER_TWO] = 1'b0;
    assign raw[`IFC_BIT_CLK_MATCH] = 1'b0;
    assign raw[`IFC_BIT_TICK]      = 1'b0;
    assign raw[`IFC_BIT_MODEM]     = 1'b0;
    assign raw[`IFC_BIT_SER_DONE]  = 1'b0;

    // Latched sources: set events (peripheral pulses; battery and media edges detected here)
    // RL8: battery falling edge
    assign set_ev[`IFC_BIT_BATT_LOW]  = batt_good_d & ~battery_good_input_in;
    // RL9: media rising edge
    assign set_ev[`IFC_BIT_MEDIA]     = ~media_d & media_change_input_in;
    assign set_ev[`IFC_BIT_WATCHDOG]  = watchdog_expired_in;
    assign set_ev[`IFC_BIT_TIMER_ONE] = first_timer_underflow_in;
    assign set_ev[`IFC_BIT_TIMER_TWO] = second_timer_underflow_in;
    assign set_ev[`IFC_BIT_CLK_MATCH] = clock_match_in;
    assign set_ev[`IFC_BIT_TICK]      = tick_in;
    assign set_ev[`IFC_BIT_MODEM]     = modem_change_in;
    assign set_ev[`IFC_BIT_SER_DONE]  = serial_transfer_done_request_in;
    assign set_ev[`IFC_BIT_EXT_FAST]  = 1'b0;
    assign set_ev[`IFC_BIT_SOUND]     = 1'b0;
    assign set_ev[`IFC_BIT_EXT3:`IFC_BIT_EXT1] = 3'h0;
    assign set_ev[`IFC_BIT_UART_TX]   = 1'b0;
    assign set_ev[`IFC_BIT_UART_RX]   = 1'b0;

    // RL22: strobes are write-only, data ignored
    // RL8: battery ack
    assign clr_ev[`IFC_BIT_BATT_LOW]  = battery_low_ack_loc_wr_in;
    // RL9: media ack
    assign clr_ev[`IFC_BIT_MEDIA]     = media_change_ack_loc_wr_in;
    // RL10: tick clears both
    assign clr_ev[`IFC_BIT_WATCHDOG]  = tick_ack_loc_wr_in;
    assign clr_ev[`IFC_BIT_TICK]      = tick_ack_loc_wr_in;
    // RL11: timer one ack
    assign clr_ev[`IFC_BIT_TIMER_ONE] = timer_one_ack_loc_wr_in;
    // RL12: timer two ack
    assign clr_ev[`IFC_BIT_TIMER_TWO] = timer_two_ack_loc_wr_in;
    // RL13: clock match ack
    assign clr_ev[`IFC_BIT_CLK_MATCH] = clock_match_ack_loc_wr_in;
    // RL14: modem ack
    assign clr_ev[`IFC_BIT_MODEM]     = modem_change_ack_loc_wr_in;
    // RL21: cleared by data read
    assign clr_ev[`IFC_BIT_SER_DONE]  = serial_adc_data_reg_rd_in;
    assign clr_ev[`IFC_BIT_EXT_FAST]  = 1'b0;
    // Sound request is a level; its ack clears the sound latch below
    assign clr_ev[`IFC_BIT_SOUND]     = 1'b0;
    assign clr_ev[`IFC_BIT_EXT3:`IFC_BIT_EXT1] = 3'h0;
    assign clr_ev[`IFC_BIT_UART_TX]   = 1'b0;
    assign clr_ev[`IFC_BIT_UART_RX]   = 1'b0;

    // Set wins over a same-cycle clear so no event is lost
    genvar i;
    generate
        for (i = 0; i < NUM_SRC; i = i + 1) begin : g_latch
            always @(posedge core_clk_in or negedge rstn_in) begin
                if (!rstn_in) begin
                    latch_q[i] <= 1'b0;
                end else if (set_ev[i]) begin
                    latch_q[i] <= 1'b1;
                end else if (clr_ev[i]) begin
                    latch_q[i] <= 1'b0;
                end
            end
        end
    endgenerate

    // Sound latch: held while the codec asserts, dropped on ack write.
    // RL15: sound ack
    reg sound_hold;
    always @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sound_hold <= 1'b0;
        end else if (sound_request_in) begin
            sound_hold <= 1'b1;
        end else if (sound_ack_loc_wr_in) begin
            sound_hold <= 1'b0;
        end
    end

    // RL1: sixteen combined sources
    assign active = raw | latch_q |
                    ({{(NUM_SRC-1){1'b0}}, sound_hold} << `IFC_BIT_SOUND);
    // RL5: mask gating
    assign enabled = active & mask_in;
    assign any_enabled = |enabled;

    always @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            batt_good_d  <= 1'b1;
            media_d      <= 1'b0;
            status_out   <= 16'h0000;
            fast_req_out <= 1'b0;
            norm_req_out <= 1'b0;
        end else begin
            batt_good_d  <= battery_good_input_in;
            media_d      <= media_change_input_in;
            // RL6: status of active sources
            status_out   <= active;
            // RL20: bits 0-3 fast
            // RL23: OR per class
            fast_req_out <= |(enabled & `IFC_FAST_MASK);
            // RL2: twelve normal sources
            // RL3: separate fast line outranks
            norm_req_out <= |(enabled & `IFC_NORM_MASK);
        end
    end

    // Power state control
    always @* begin
        next_pwr_state = pwr_state;
        case (pwr_state)
            `IFC_ST_RUN: begin
                if (standby_entry_loc_wr_in) begin
                    next_pwr_state = `IFC_ST_SB_WAIT;
                end else if (idle_entry_loc_wr_in) begin
                    next_pwr_state = `IFC_ST_IDLE;
                end
            end
            // RL16: wake on enabled request
            // RL17: no exit when all masked
            `IFC_ST_IDLE: begin
                if (any_enabled) begin
                    next_pwr_state = `IFC_ST_RUN;
                end
            end
            // RL19: wait DRAM cycle end
            `IFC_ST_SB_WAIT: begin
                if (!dram_cycle_busy_in) begin
                    next_pwr_state = `IFC_ST_STANDBY;
                end
            end
            // Oscillator restarts on an external wake source
            `IFC_ST_STANDBY: begin
                if (wake_in) begin
                    next_pwr_state = `IFC_ST_RUN;
                end
            end
            default: next_pwr_state = `IFC_ST_RUN;
        endcase
    end

    always @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pwr_state        <= `IFC_ST_RUN;
            self_refresh_out <= 1'b0;
        end else begin
            pwr_state <= next_pwr_state;
            // RL18: self-refresh if enabled
            if (pwr_state == `IFC_ST_SB_WAIT && !dram_cycle_busy_in) begin
                self_refresh_out <= refresh_enable_bit_in;
            end else if (next_pwr_state == `IFC_ST_RUN) begin
                self_refresh_out <= 1'b0;
            end
        end
    end

    // High stops the processor clock
    assign cpu_clk_gate_out = (pwr_state != `IFC_ST_RUN);
    // RL18: oscillator stop
    assign osc_stop_out = (pwr_state == `IFC_ST_STANDBY);

endmodule

//--- logic/ifc_consts.vh
// Purpose: Constants for the interrupt combiner with end-of-interrupt.
// Assumes: Included by the combiner design file only.
// Notes:   Bit positions match the mask and status bit order.
`ifndef IFC_CONSTS_VH
`define IFC_CONSTS_VH

`define IFC_NUM_SRC        16
`define IFC_NUM_FAST       4
`define IFC_FAST_MASK      16'h000f
`define IFC_NORM_MASK      16'hfff0
`define IFC_MASK_RESET     16'h0000

// Fast-class bit positions
`define IFC_BIT_EXT_FAST   0
`define IFC_BIT_BATT_LOW   1
`define IFC_BIT_WATCHDOG   2
`define IFC_BIT_MEDIA      3
// Normal-class bit positions
`define IFC_BIT_SOUND      4
`define IFC_BIT_EXT1       5
`define IFC_BIT_EXT2       6
`define IFC_BIT_EXT3       7
`define IFC_BIT_TIMER_ONE  8
`define IFC_BIT_TIMER_TWO  9
`define IFC_BIT_CLK_MATCH  10
`define IFC_BIT_TICK       11
`define IFC_BIT_UART_TX    12
`define IFC_BIT_UART_RX    13
`define IFC_BIT_MODEM      14
`define IFC_BIT_SER_DONE   15

// Power states
`define IFC_ST_RUN         2'h0
`define IFC_ST_IDLE        2'h1
`define IFC_ST_SB_WAIT     2'h2
`define IFC_ST_STANDBY     2'h3

`endif

//--- verif/ifc_combiner_props.sv
// Purpose: Port checks for the interrupt combiner.
// Assumes: Bound to every ifc_combiner instance.
// Notes:   Latched paths take two edges from cause to status.
`timescale 1ns/1ps
module ifc_combiner_props #(
    parameter NUM_SRC = 16
) (
    input wire               core_clk_in,
    input wire               rstn_in,
    input wire [NUM_SRC-1:0] mask_in,
    input wire               external_fast_request_in,
    input wire               tick_in,
    input wire               watchdog_expired_in,
    input wire               tick_ack_loc_wr_in,
    input wire               idle_entry_loc_wr_in,
    input wire               refresh_enable_bit_in,
    input wire               dram_cycle_busy_in,
    input wire [NUM_SRC-1:0] status_out,
    input wire               fast_req_out,
    input wire               norm_req_out,
    input wire               cpu_clk_gate_out,
    input wire               osc_stop_out,
    input wire               self_refresh_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rstn_in);
    wire run = !cpu_clk_gate_out && !osc_stop_out;
    // Acks clear in every power state; this sequence checks run-state acks only
    sequence s_tick_ack;
        run && tick_ack_loc_wr_in && !tick_in && !watchdog_expired_in
            ##1 !tick_in && !watchdog_expired_in;
    endsequence
    a_fast_level: assert property ($past(rstn_in) |->
        status_out[0] == $past(external_fast_request_in))
        else $error("fast level bit wrong");
    a_fast_or: assert property ($past(rstn_in) &&
        mask_in == $past(mask_in) |->
        fast_req_out == |(status_out[3:0] & mask_in[3:0]))
        else $error("fast request not OR of enabled bits");
    a_norm_or: assert property ($past(rstn_in) &&
        mask_in == $past(mask_in) |->
        norm_req_out == |(status_out[15:4] & mask_in[15:4]))
        else $error("normal request not OR of enabled bits");
    a_tick_set: assert property (run && tick_in |-> ##2 status_out[11])
        else $error("tick not latched");
    a_tick_clear: assert property (s_tick_ack |->
        ##1 !status_out[11] && !status_out[2])
        else $error("tick ack left tick or watchdog set");
    a_idle_enter: assert property (run && idle_entry_loc_wr_in |->
        ##1 cpu_clk_gate_out) else $error("idle did not stop clock");
    a_idle_stuck: assert property (cpu_clk_gate_out &&
        !osc_stop_out && mask_in == 0 && dram_cycle_busy_in |=>
        cpu_clk_gate_out) else $error("left idle with all masked");
    a_standby_sync: assert property ($rose(osc_stop_out) |->
        !$past(dram_cycle_busy_in)) else $error("standby cut a cycle");
    a_refresh_copy: assert property ($rose(osc_stop_out) |->
        self_refresh_out == $past(refresh_enable_bit_in))
        else $error("self refresh not per enable bit");
endmodule
bind ifc_combiner ifc_combiner_props #(.NUM_SRC(NUM_SRC)) u_props (
    .core_clk_in, .rstn_in, .mask_in, .external_fast_request_in,
    .tick_in, .watchdog_expired_in, .tick_ack_loc_wr_in,
    .idle_entry_loc_wr_in, .refresh_enable_bit_in, .dram_cycle_busy_in,
    .status_out, .fast_req_out, .norm_req_out, .cpu_clk_gate_out,
    .osc_stop_out, .self_refresh_out);

//--- verif/ifc_cpu_model.sv
// Purpose: Processor core as seen from its two request inputs.
// Assumes: Requests sampled on the system clock.
// Notes:   Reports the class it would service each cycle.
`timescale 1ns/1ps
module ifc_cpu_model (
    input  wire       core_clk_in,
    input  wire       fast_req_in,
    input  wire       norm_req_in,
    input  wire       clk_gate_in,
    output reg  [1:0] taken_out
);
    initial taken_out = 2'h0;
    // fast class first
    // A stopped core takes nothing, so the gate is looked at first
    always @(posedge core_clk_in) begin
        taken_out <= clk_gate_in ? 2'h0 : fast_req_in ? 2'h2 :
                     norm_req_in ? 2'h1 : 2'h0;
    end
endmodule

//--- verif/test_irq_fiq_combiner_with_eoi.sv
// Purpose: Self-checking bench for the interrupt combiner.
// Assumes: Inputs change on the falling clock edge.
// Notes:   Levels, masks, latches and acks, idle, standby.
`timescale 1ns/1ps
module test_irq_fiq_combiner_with_eoi;
    localparam [143:0] SETS = {16'h8000, 16'h0010, 16'h4000, 16'h0400,
                               16'h0200, 16'h0100, 16'h0804, 16'h0008,
                               16'h0002};
    localparam [35:0]  ACKS = 36'h0_8765_4321;
    reg         core_clk_in;
    reg         rstn_in;
    reg  [15:0] mask;
    reg  [15:0] ev;
    reg  [10:0] st;
    reg  [2:0]  misc;
    reg  [15:0] b;
    wire [15:0] status;
    wire        fast_req, norm_req, gate, osc, sref;
    wire [1:0]  taken;
    integer     miscompares, comparisons, i, n;
    ifc_combiner DUT (
        .core_clk_in(core_clk_in), .rstn_in(rstn_in), .mask_in(mask),
        .external_fast_request_in(ev[0]), .battery_good_input_in(ev[1]),
        .watchdog_expired_in(ev[2]), .media_change_input_in(ev[3]),
        .sound_request_in(ev[4]), .ext_request_in(ev[7:5]),
        .first_timer_underflow_in(ev[8]),
        .second_timer_underflow_in(ev[9]),
        .clock_match_in(ev[10]), .tick_in(ev[11]),
        .uart_tx_request_in(ev[12]), .uart_rx_request_in(ev[13]),
        .modem_change_in(ev[14]), .serial_transfer_done_request_in(ev[15]),
        .serial_adc_data_reg_rd_in(st[0]),
        .battery_low_ack_loc_wr_in(st[1]),
        .media_change_ack_loc_wr_in(st[2]), .tick_ack_loc_wr_in(st[3]),
        .timer_one_ack_loc_wr_in(st[4]), .timer_two_ack_loc_wr_in(st[5]),
        .clock_match_ack_loc_wr_in(st[6]),
        .modem_change_ack_loc_wr_in(st[7]), .sound_ack_loc_wr_in(st[8]),
        .idle_entry_loc_wr_in(st[9]), .standby_entry_loc_wr_in(st[10]),
        .refresh_enable_bit_in(misc[0]), .dram_cycle_busy_in(misc[1]),
        .wake_in(misc[2]), .status_out(status), .fast_req_out(fast_req),
        .norm_req_out(norm_req), .cpu_clk_gate_out(gate),
        .osc_stop_out(osc), .self_refresh_out(sref));
    ifc_cpu_model CPU (.core_clk_in(core_clk_in), .fast_req_in(fast_req),
        .norm_req_in(norm_req), .clk_gate_in(gate), .taken_out(taken));
    task chk(input [15:0] got, input [15:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("FAIL %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task step(input integer k);
        repeat (k) @(negedge core_clk_in);
    endtask
    // One-cycle toggle, so battery good gives a falling edge
    task flip_ev(input [15:0] m);
        begin ev = ev ^ m; step(1); ev = ev ^ m; end
    endtask
    task strobe(input integer k);
        begin st[k] = 1'b1; step(1); st[k] = 1'b0; end
    endtask
    task finish_test;
        begin
            $display("comparisons %0d miscompares %0d", comparisons,
                     miscompares);
            if (miscompares == 0 && comparisons > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    initial begin
        core_clk_in = 1'b0;
        forever #5 core_clk_in = ~core_clk_in;
    end
    initial begin
        #20000;
        miscompares = miscompares + 1;
        finish_test;
    end
    initial begin
        miscompares = 0;
        comparisons = 0;
        rstn_in = 1'b0;
        mask = 16'h0000;
        ev = 16'h0002;
        st = 11'h000;
        misc = 3'h0;
        step(4);
        rstn_in = 1'b1;
        chk(status, 16'h0000); // status clear after reset
        chk({osc, gate, fast_req, norm_req, sref}, 16'h0000); // running, all outputs low
        mask = 16'hffff;
        ev = 16'h30e3;
        step(1);
        chk(status, 16'h30e1); // levels seen
        chk({fast_req, norm_req}, 2'b11); // both classes
        ev = 16'h0002; // cleared at the source
        step(1);
        chk(status, 16'h0000); // levels dropped
        ev = 16'h0023;
        for (i = 0; i < 4; i = i + 1) begin
            mask = {10'h000, i[1], 4'h0, i[0]};
            step(2);
            chk({fast_req, norm_req, taken},
                {i[0], i[1], i[0] ? 2'h2 : {1'b0, i[1]}}); // mask
        end
        ev = 16'h0002;
        mask = 16'hffff;
        for (i = 0; i < 9; i = i + 1) begin
            b = SETS[i*16 +: 16];
            flip_ev(b);
            step(1);
            chk(status, b); // latched
            chk({fast_req, norm_req}, {|b[3:0], |b[15:4]}); // class
            strobe(ACKS[((i+1)%9)*4 +: 4]);
            step(1);
            chk(status, b); // other ack no effect
            strobe(ACKS[i*4 +: 4]);
            step(1);
            chk(status, 16'h0000);
        end
        misc = 3'h2;
        mask = 16'h0000;
        strobe(9);
        chk(gate, 1'b1); // clock stopped
        ev = 16'h0022;
        step(4);
        chk(gate, 1'b1); // masked source no wake
        mask = 16'h0020;
        n = 0;
        while (gate === 1'b1 && n < 10) begin step(1); n = n + 1; end
        chk({gate, n < 4}, 2'b01); // enabled source wakes
        ev = 16'h0002;
        mask = 16'h0000;
        strobe(9);
        step(3);
        rstn_in = 1'b0;
        step(1);
        rstn_in = 1'b1;
        chk(gate, 1'b0); // reset leaves idle
        for (i = 1; i >= 0; i = i - 1) begin
            misc = {2'b01, i[0]};
            strobe(10);
            step(3);
            chk({gate, osc}, 2'b10); // waits for dram cycle
            misc[1] = 1'b0;
            step(2);
            chk({osc, sref}, {1'b1, i[0]}); // oscillator stopped
            misc[2] = 1'b1;
            step(2);
            misc[2] = 1'b0;
            chk({osc, sref, gate}, 3'b000); // wake restarts oscillator
        end
        finish_test;
    end
endmodule
